/* hw/adc_result_hold_regs.sv */
/*
 * Holding registers for the conversion results of two converter channels,
 * with a sticky interrupt status, enable and clear register.
 * Assumes the sequencer and the register port run on CLK_I, and that the port
 * master keeps one-cycle strobes and takes read data in the following cycle.
 */
// The address map and the address-and-strobe port were chosen for this implementation.
// Function
// - Result bits 9:2 at 15:8, 1:0 at 7:6.
// - New stored result sets present flag, bit 0.
// - Reading lower result byte clears present flag.
// - Overwrite before both halves read sets overrun.
// - Reading the overrun flag clears it.
module adc_result_hold_regs
    import adc_result_pkg::*;
#(
    // Number of channels; the register map serves exactly two.
    parameter int CHANNELS = 2
) (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic NRST_I,
    // Register port.
    input wire logic [adc_result_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [1:0] BYTE_EN_I,
    input wire logic [adc_result_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [adc_result_pkg::DATA_W-1:0] RDATA_O,
    // Converter sequencer side.
    input wire adc_result_pkg::conv_store_s [CHANNELS-1:0] STORE_I,
    // Interrupt.
    output logic IRQ_O
);

    import adc_result_pkg::*;

    // The address map and the status layout are fixed for two channels.
    if (CHANNELS != NUM_CH) begin : g_bad_channels
        $error("adc_result_hold_regs serves exactly two channels");
    end

    // Register images of the channels.
    logic [REG_W-1:0] chan_reg [CHANNELS];
    // Events of the channels.
    chan_event_s chan_evt [CHANNELS];
    // Channel register selected by the address.
    logic [CHANNELS-1:0] sel_chan;
    // Lane reads forwarded to each channel.
    lane_read_s lane_rd [CHANNELS];
    // Collected events in status layout.
    logic [IRQ_W-1:0] events;

    // Interrupt status, sticky.
    logic [IRQ_W-1:0] sts_q;
    logic [IRQ_W-1:0] sts_d;
    // Interrupt enable.
    logic [IRQ_W-1:0] en_q;
    logic [IRQ_W-1:0] en_d;
    // Interrupt output register.
    logic irq_q;

    // Read data register and its next value.
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // Register-write decodes.
    logic wr_enable;
    logic wr_clear;

    // One holder per channel; each sees only its own lane reads.
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        // Channel i sits one stride above channel i-1.
        assign sel_chan[i] = (ADDR_I == OFS_RESULT_CH4 + ADDR_W'(i) * REG_STRIDE);

        // A lane is read only when the strobe, the address and the lane agree.
        // Byte-wide reads still work, which lets the halves be fetched apart.
        assign lane_rd[i].rd_lo = RD_I && sel_chan[i] && BYTE_EN_I[0];
        assign lane_rd[i].rd_hi = RD_I && sel_chan[i] && BYTE_EN_I[1];

        adc_result_chan u_chan (
            .clk_i(CLK_I),
            .nrst_i(NRST_I),
            .store_i(STORE_I[i]),
            .rd_i(lane_rd[i]),
            .reg_o(chan_reg[i]),
            .evt_o(chan_evt[i])
        );

        // Place the events in the status layout.
        assign events[IRQ_NEW_LSB + i] = chan_evt[i].new_result;
        assign events[IRQ_OVR_LSB + i] = chan_evt[i].overrun;
    end

    // Write decodes; writes to the result registers fall through and do nothing.
    assign wr_enable = WR_I && (ADDR_I == OFS_IRQ_ENABLE);
    assign wr_clear = WR_I && (ADDR_I == OFS_IRQ_CLEAR);

    // Next status: software clears with ones, but a same-cycle event wins.
    always_comb begin
        sts_d = sts_q;
        if (wr_clear) begin
            sts_d = sts_d & ~WDATA_I[IRQ_W-1:0];
        end
        sts_d = sts_d | events;
    end

    // Next enable value.
    always_comb begin
        en_d = en_q;
        if (wr_enable) begin
            en_d = WDATA_I[IRQ_W-1:0];
        end
    end

    // Status register.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sts_q <= IRQ_RST;
        end else begin
            sts_q <= sts_d;
        end
    end

    // Enable register.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            en_q <= IRQ_RST;
        end else begin
            en_q <= en_d;
        end
    end

    // The interrupt is built from the next values, so it tracks the
    // registers cycle for cycle while still leaving a flip-flop.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_d & en_d);
        end
    end

    // Read multiplexer; unmapped and write-only offsets read zero.
    // The image is taken before any read clear lands, so the flags that a
    // read returns are those that were standing when it was made.
    always_comb begin
        rdata_d = RDATA_RST;
        if (sel_chan[0]) begin
            rdata_d[REG_W-1:0] = chan_reg[0];
        end else if (sel_chan[1]) begin
            rdata_d[REG_W-1:0] = chan_reg[1];
        end else if (ADDR_I == OFS_IRQ_STATUS) begin
            rdata_d[IRQ_W-1:0] = sts_q;
        end else if (ADDR_I == OFS_IRQ_ENABLE) begin
            rdata_d[IRQ_W-1:0] = en_q;
        end else begin
            rdata_d = RDATA_RST;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rdata_q <= RDATA_RST;
        end else if (RD_I) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= RDATA_RST;
        end
    end

    // Outputs come straight from flip-flops.
    assign RDATA_O = rdata_q;
    assign IRQ_O = irq_q;

    // A stored value reads back in place on a read in the cycle after the store.
    property p_layout;
        @(posedge CLK_I) disable iff (!NRST_I)
            STORE_I[0].store ##1 (RD_I && sel_chan[0] && !STORE_I[0].store)
            |=> (RDATA_O[15:8] == $past(STORE_I[0].value[9:2], 2))
                && (RDATA_O[7:6] == $past(STORE_I[0].value[1:0], 2));
    endproperty
    a_layout: assert property (p_layout) else $error("result bits misplaced");

    // A store is visible as present on a read in the cycle after it.
    property p_present_read;
        @(posedge CLK_I) disable iff (!NRST_I)
            STORE_I[1].store ##1 (RD_I && sel_chan[1] && !STORE_I[1].store) |=> RDATA_O[0];
    endproperty
    a_present_read: assert property (p_present_read) else $error("present flag not read back");

    // Two reads of the lower byte with no store between: the second shows no flag.
    property p_clear_read;
        @(posedge CLK_I) disable iff (!NRST_I)
            (RD_I && sel_chan[0] && BYTE_EN_I[0] && !STORE_I[0].store)
            ##1 (RD_I && sel_chan[0] && !STORE_I[0].store)
            |=> (RDATA_O[1:0] == 2'b00);
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("flags survived a read");

    // Reserved bits and everything above the register read zero.
    property p_reserved;
        @(posedge CLK_I) disable iff (!NRST_I)
            (RD_I && (|sel_chan)) |=> (RDATA_O[5:2] == 4'h0) && (RDATA_O[31:16] == 16'h0000);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    // An overwrite raises its status bit on the next edge.
    property p_ovr_status;
        @(posedge CLK_I) disable iff (!NRST_I) chan_evt[0].overrun |=> sts_q[IRQ_OVR_LSB];
    endproperty
    a_ovr_status: assert property (p_ovr_status) else $error("overrun status not raised");

    // With no read strobe the read data stay at zero.
    property p_rdata_idle;
        @(posedge CLK_I) disable iff (!NRST_I) !RD_I |=> (RDATA_O == RDATA_RST);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    // The interrupt follows enabled status bits.
    property p_irq;
        @(posedge CLK_I) disable iff (!NRST_I) ##1 (IRQ_O == |(sts_q & en_q));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    // A write to the first result register leaves the value bits that it shows unchanged.
    property p_write_ignored;
        @(posedge CLK_I) disable iff (!NRST_I)
            (WR_I && sel_chan[0] && !STORE_I[0].store)
            |=> (chan_reg[0][15:6] == $past(chan_reg[0][15:6]));
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write reached result");

    // The second channel keeps the same layout as the first.
    // A store followed at once by a read is the tightest case the port allows.
    property p_layout_ch5;
        @(posedge CLK_I) disable iff (!NRST_I)
            STORE_I[1].store ##1 (RD_I && sel_chan[1] && !STORE_I[1].store)
            |=> (RDATA_O[15:8] == $past(STORE_I[1].value[9:2], 2))
                && (RDATA_O[7:6] == $past(STORE_I[1].value[1:0], 2));
    endproperty
    a_layout_ch5: assert property (p_layout_ch5) else $error("second channel bits misplaced");

    // A store on the first channel is visible as present on the read that follows it.
    property p_present_read_ch4;
        @(posedge CLK_I) disable iff (!NRST_I)
            STORE_I[0].store ##1 (RD_I && sel_chan[0] && !STORE_I[0].store) |=> RDATA_O[0];
    endproperty
    a_present_read_ch4: assert property (p_present_read_ch4) else $error("present flag not read back");

    // A new result raises its status bit on the next edge, whatever a clear write does.
    // Losing an event to a same-cycle clear would make software miss an interrupt.
    property p_new_status_ch4;
        @(posedge CLK_I) disable iff (!NRST_I) chan_evt[0].new_result |=> sts_q[IRQ_NEW_LSB];
    endproperty
    a_new_status_ch4: assert property (p_new_status_ch4) else $error("new result status not raised");

    // The same holds for the second channel.
    property p_new_status_ch5;
        @(posedge CLK_I) disable iff (!NRST_I) chan_evt[1].new_result |=> sts_q[IRQ_NEW_LSB + 1];
    endproperty
    a_new_status_ch5: assert property (p_new_status_ch5) else $error("new result status not raised");

    // An overwrite on the second channel raises its status bit on the next edge.
    property p_ovr_status_ch5;
        @(posedge CLK_I) disable iff (!NRST_I) chan_evt[1].overrun |=> sts_q[IRQ_OVR_LSB + 1];
    endproperty
    a_ovr_status_ch5: assert property (p_ovr_status_ch5) else $error("overrun status not raised");

    // A clear write with a one drops the status bit when no event competes.
    property p_sts_clear;
        @(posedge CLK_I) disable iff (!NRST_I)
            (wr_clear && WDATA_I[IRQ_NEW_LSB] && !chan_evt[0].new_result) |=> !sts_q[IRQ_NEW_LSB];
    endproperty
    a_sts_clear: assert property (p_sts_clear) else $error("status bit survived a clear");

    // An enable write lands whole on the next edge.
    property p_en_write;
        @(posedge CLK_I) disable iff (!NRST_I) wr_enable |=> (en_q == $past(WDATA_I[IRQ_W-1:0]));
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    // A status read returns the bits standing at the strobe and zeros above them.
    // The status register has no read clear, so only the clear register removes bits.
    property p_rdata_status;
        @(posedge CLK_I) disable iff (!NRST_I) (RD_I && (ADDR_I == OFS_IRQ_STATUS))
            |=> (RDATA_O[IRQ_W-1:0] == $past(sts_q)) && (RDATA_O[DATA_W-1:IRQ_W] == '0);
    endproperty
    a_rdata_status: assert property (p_rdata_status) else $error("status read back wrong");

    // Unmapped and write-only offsets read zero.
    property p_unmapped;
        @(posedge CLK_I) disable iff (!NRST_I)
            (RD_I && !(|sel_chan) && (ADDR_I != OFS_IRQ_STATUS) && (ADDR_I != OFS_IRQ_ENABLE))
            |=> (RDATA_O == RDATA_RST);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped offset read nonzero");

    // An enabled new result on the second channel raises the interrupt on the next edge.
    property p_irq_new_ch5;
        @(posedge CLK_I) disable iff (!NRST_I) (chan_evt[1].new_result && en_d[IRQ_NEW_LSB + 1]) |=> IRQ_O;
    endproperty
    a_irq_new_ch5: assert property (p_irq_new_ch5) else $error("interrupt missed an enabled event");

endmodule : adc_result_hold_regs

/* hw/adc_result_pkg.sv */
/*
 * Shared constants and carrier types for the conversion result holding registers.
 * Assumes a single peripheral clock shared by the converter sequencer and the register port.
 */
package adc_result_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Width of one conversion result.
    localparam int RES_W = 10;

    // Number of result channels held by this block.
    localparam int NUM_CH = 2;

    // Width of one result register.
    localparam int REG_W = 16;

    // Byte offsets of the registers; one aligned word each.
    localparam logic [ADDR_W-1:0] OFS_RESULT_CH4 = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h10;

    // Field positions inside a result register.
    localparam int UPPER_LSB = 8;
    localparam int LOWER_LSB = 6;
    localparam int OVR_BIT = 1;
    localparam int PRESENT_BIT = 0;

    // Field positions inside the interrupt registers.
    localparam int IRQ_NEW_LSB = 0;
    localparam int IRQ_OVR_LSB = 2;
    localparam int IRQ_W = 4;

    // Values after reset.
    localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // A new result offered by the converter sequencer.
    typedef struct packed {
        logic store;
        logic [RES_W-1:0] value;
    } conv_store_s;

    // Which byte lanes of a result register a read touches.
    typedef struct packed {
        logic rd_hi;
        logic rd_lo;
    } lane_read_s;

    // One-cycle events raised by a channel.
    typedef struct packed {
        logic new_result;
        logic overrun;
    } chan_event_s;

endpackage : adc_result_pkg

/* hw/adc_result_chan.sv */
/*
 * One result holding register: value, result-present flag and overrun flag.
 * Assumes the parent decodes byte-lane reads and keeps the register port timing.
 */
module adc_result_chan
    import adc_result_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // New result from the sequencer.
    input wire conv_store_s store_i,
    // Byte lanes read this cycle.
    input wire lane_read_s rd_i,
    // Register image and events.
    output logic [REG_W-1:0] reg_o,
    output chan_event_s evt_o
);

    // Stored result.
    logic [RES_W-1:0] value_q;
    // Result-present flag.
    logic present_q;
    // Overrun flag.
    logic ovr_q;
    // Halves not yet read since the last store: [1] upper, [0] lower.
    logic [1:0] unread_q;
    // An overwrite of a value not fully read.
    logic overwrite;

    assign overwrite = store_i.store && (|unread_q);

    // Only the sequencer changes the value; bus writes never reach it.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            value_q <= RESULT_RST;
        end else if (store_i.store) begin
            value_q <= store_i.value;
        end
    end

    // A store sets the flag and wins over a read of the lower byte.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            present_q <= 1'b0;
        end else if (store_i.store) begin
            present_q <= 1'b1;
        end else if (rd_i.rd_lo) begin
            present_q <= 1'b0;
        end
    end

    // Halves are tracked apart, since software may read them one byte at a time.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            unread_q <= 2'b00;
        end else if (store_i.store) begin
            unread_q <= 2'b11;
        end else begin
            unread_q <= unread_q & ~{rd_i.rd_hi, rd_i.rd_lo};
        end
    end

    // The flag sits in the lower byte, so a lower-byte read clears it; set wins.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ovr_q <= 1'b0;
        end else if (overwrite) begin
            ovr_q <= 1'b1;
        end else if (rd_i.rd_lo) begin
            ovr_q <= 1'b0;
        end
    end

    // Register image; bits 5 to 2 are tied low.
    always_comb begin
        reg_o = '0;
        reg_o[UPPER_LSB +: 8] = value_q[RES_W-1:2];
        reg_o[LOWER_LSB +: 2] = value_q[1:0];
        reg_o[OVR_BIT] = ovr_q;
        reg_o[PRESENT_BIT] = present_q;
    end

    // Events for the interrupt status.
    assign evt_o.new_result = store_i.store;
    assign evt_o.overrun = overwrite;

    property p_present_set;
        @(posedge clk_i) disable iff (!nrst_i) store_i.store |=> present_q;
    endproperty
    a_present_set: assert property (p_present_set) else $error("present flag not set after store");

    property p_present_clr;
        @(posedge clk_i) disable iff (!nrst_i) (rd_i.rd_lo && !store_i.store) |=> !present_q;
    endproperty
    a_present_clr: assert property (p_present_clr) else $error("present flag not cleared by read");

    property p_ovr_set;
        @(posedge clk_i) disable iff (!nrst_i)
            store_i.store ##1 (store_i.store && !rd_i.rd_hi && !rd_i.rd_lo) |=> ovr_q;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged on overwrite");

    property p_ovr_clr;
        @(posedge clk_i) disable iff (!nrst_i) (rd_i.rd_lo && !store_i.store) |=> !ovr_q;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared by read");

    property p_value_hold;
        @(posedge clk_i) disable iff (!nrst_i) !store_i.store |=> $stable(value_q);
    endproperty
    a_value_hold: assert property (p_value_hold) else $error("value changed without store");

endmodule : adc_result_chan

/* testbench/adc_result_hold_regs_tb.sv */
/*
 * Self-checking testbench for the two conversion result holding registers.
 * Assumes the register port and the sequencer store link both run on CLK_I,
 * read data arrive one cycle after the read strobe, and stores take one cycle.
 */
module adc_result_hold_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_result_pkg::*;

    // Clock, reset and register port stimulus.
    logic clk;
    logic nrst;
    logic [ADDR_W-1:0] addr;
    logic [1:0] byte_en;
    logic [DATA_W-1:0] wdata;
    logic wr_strobe;
    logic rd_strobe;
    logic [DATA_W-1:0] rdata;
    // Sequencer stores, entry 0 for channel 4 and entry 1 for channel 5.
    conv_store_s [1:0] store_in;
    logic irq;
    // Scoreboard counters.
    int err_total;
    int tests_run;
    logic [31:0] d;

    adc_result_hold_regs #(.CHANNELS(2)) dut (
        .CLK_I(clk),
        .NRST_I(nrst),
        .ADDR_I(addr),
        .BYTE_EN_I(byte_en),
        .WDATA_I(wdata),
        .WR_I(wr_strobe),
        .RD_I(rd_strobe),
        .RDATA_O(rdata),
        .STORE_I(store_in),
        .IRQ_O(irq)
    );

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Expected register image: value high bits, low bits, zero gap, overrun, present.
    function automatic logic [31:0] img(input logic [9:0] v, input logic o, input logic p);
        return {16'h0000, v, 4'h0, o, p};
    endfunction : img

    // Compares one observed value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle read; the data are taken in the single cycle they stand.
    task automatic bus_rd(input logic [7:0] a, input logic [1:0] be, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        byte_en <= be;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        q = rdata;
    endtask : bus_rd

    // One-cycle write; the slave never stalls, so no wait is needed.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
        #1;
    endtask : bus_wr

    // One-cycle store pulse from the sequencer on channel ch.
    task automatic put_result(input int ch, input logic [9:0] v);
        @(posedge clk);
        store_in[ch] <= '{store: 1'b1, value: v};
        @(posedge clk);
        store_in[ch].store <= 1'b0;
        #1;
    endtask : put_result

    // Both result registers and the interrupt read zero straight out of reset.
    task automatic t_reset();
        bus_rd(OFS_RESULT_CH4, 2'b11, d);
        check(d, 32'h0);
        bus_rd(OFS_RESULT_CH4 + REG_STRIDE, 2'b11, d);
        check(d, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // A store shows up with its fields placed and present set; a full read clears it.
    task automatic t_store_read();
        put_result(0, 10'h2c5);
        put_result(1, 10'h13a);
        bus_rd(OFS_RESULT_CH4, 2'b11, d);
        check(d, img(10'h2c5, 1'b0, 1'b1));
        // Read data stand for one cycle only.
        @(posedge clk);
        #1;
        check(rdata, 32'h0);
        bus_rd(OFS_RESULT_CH4, 2'b11, d);
        check(d, img(10'h2c5, 1'b0, 1'b0));
        bus_rd(OFS_RESULT_CH4 + REG_STRIDE, 2'b11, d);
        check(d, img(10'h13a, 1'b0, 1'b1));
        $display("test store_read done");
    endtask : t_store_read

    // Two stores with no read in between raise overrun; reading it clears it.
    task automatic t_overrun();
        put_result(1, 10'h0aa);
        put_result(1, 10'h355);
        bus_rd(OFS_RESULT_CH4 + REG_STRIDE, 2'b11, d);
        check(d, img(10'h355, 1'b1, 1'b1));
        bus_rd(OFS_RESULT_CH4 + REG_STRIDE, 2'b11, d);
        check(d, img(10'h355, 1'b0, 1'b0));
        $display("test overrun done");
    endtask : t_overrun

    // Byte reads: only the upper half read still leaves the result unread.
    task automatic t_byte_order();
        put_result(0, 10'h3ff);
        bus_rd(OFS_RESULT_CH4, 2'b10, d);
        put_result(0, 10'h001);
        bus_rd(OFS_RESULT_CH4, 2'b11, d);
        check(d, img(10'h001, 1'b1, 1'b1));
        // Upper then lower, one of the two orders the halves accept, counts as fully read.
        put_result(0, 10'h0f0);
        bus_rd(OFS_RESULT_CH4, 2'b10, d);
        bus_rd(OFS_RESULT_CH4, 2'b01, d);
        put_result(0, 10'h00f);
        bus_rd(OFS_RESULT_CH4, 2'b11, d);
        check(d, img(10'h00f, 1'b0, 1'b1));
        $display("test byte_order done");
    endtask : t_byte_order

    // A write to a result register leaves it untouched; an unmapped offset reads zero.
    task automatic t_write_ignored();
        bus_wr(OFS_RESULT_CH4, 32'hffff_ffff);
        bus_rd(OFS_RESULT_CH4, 2'b11, d);
        check(d, img(10'h00f, 1'b0, 1'b0));
        bus_rd(8'h20, 2'b11, d);
        check(d, 32'h0);
        $display("test write_ignored done");
    endtask : t_write_ignored

    // Back-to-back traffic: two stores with no gap, then three reads with the strobe held high.
    task automatic t_back_to_back();
        @(posedge clk);
        store_in[0] <= '{store: 1'b1, value: 10'h1a5};
        @(posedge clk);
        store_in[0] <= '{store: 1'b1, value: 10'h25a};
        @(posedge clk);
        // Full-width reads only; the strobe stays high for three reads in a row.
        store_in[0].store <= 1'b0;
        addr <= OFS_RESULT_CH4;
        byte_en <= 2'b11;
        rd_strobe <= 1'b1;
        @(posedge clk);
        store_in[1] <= '{store: 1'b1, value: 10'h0c3};
        #1;
        check(rdata, img(10'h25a, 1'b1, 1'b1));
        @(posedge clk);
        store_in[1].store <= 1'b0;
        addr <= OFS_RESULT_CH4 + REG_STRIDE;
        #1;
        check(rdata, img(10'h25a, 1'b0, 1'b0));
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        check(rdata, img(10'h0c3, 1'b0, 1'b1));
        $display("test back_to_back done");
    endtask : t_back_to_back

    // Interrupt: raise through an enabled event, mask it, then clear status.
    task automatic t_irq();
        bus_wr(OFS_IRQ_CLEAR, 32'h0000_000f);
        bus_wr(OFS_IRQ_ENABLE, 32'h0000_0002);
        put_result(1, 10'h155);
        check({31'h0, irq}, 32'h1);
        bus_rd(OFS_IRQ_ENABLE, 2'b11, d);
        check(d, 32'h2);
        bus_wr(OFS_IRQ_STATUS, 32'h0);
        bus_rd(OFS_IRQ_STATUS, 2'b11, d);
        check(d, 32'h2);
        bus_wr(OFS_IRQ_ENABLE, 32'h0);
        check({31'h0, irq}, 32'h0);
        bus_wr(OFS_IRQ_CLEAR, 32'h0000_0002);
        bus_rd(OFS_IRQ_STATUS, 2'b11, d);
        check(d, 32'h0);
        bus_rd(OFS_IRQ_CLEAR, 2'b11, d);
        check(d, 32'h0);
        $display("test irq done");
    endtask : t_irq

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence; reset is held for five clock cycles first.
    initial begin
        err_total = 0;
        tests_run = 0;
        nrst = 1'b0;
        addr = '0;
        byte_en = 2'b11;
        wdata = '0;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        store_in = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_store_read();
        t_overrun();
        t_byte_order();
        t_write_ignored();
        t_back_to_back();
        t_irq();
        report_and_stop();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #100us;
        err_total++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        report_and_stop();
    end

endmodule : adc_result_hold_regs_tb
